// ---- common/dacc_pkg.sv ----
// Shared constants and types for the DMA channel abort and chain control
package dacc_pkg;
	// ****************************************
	// Channel control field positions and encodings
	// ****************************************
	localparam int CTL_ENABLE_BIT = 7;
	localparam int CTL_BUFOFF_BIT = 25;
	localparam logic [1:0] SYNC_SIDE_DST = 2'h0;
	localparam logic [1:0] SYNC_SIDE_SRC = 2'h1;
	localparam logic PREFETCH_ON = 1'h1;
	// ****************************************
	// Status bit positions
	// ****************************************
	localparam int STS_DESC_BIT = 15;
	localparam int STS_ACTIVE_BIT = 7;
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [15:0] RST_COUNT = 16'h0000;
	// ****************************************
	// Channel states
	// ****************************************
	typedef enum logic [4:0] {
		DACC_IDLE = 5'h01,
		DACC_DESC = 5'h02,
		DACC_RUN = 5'h04,
		DACC_ABORT = 5'h08,
		DACC_DONE = 5'h10
	} dacc_state_t;
endpackage

// ---- hw/dacc_sync2.sv ----
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module dacc_sync2 #(
	parameter int W = 1
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} dacc_sync_t;
	dacc_sync_t st_ff, nxt_st;
	always_comb begin
		nxt_st.meta = din;
		nxt_st.sync = st_ff.meta;
	end
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign dout = st_ff.sync;
endmodule

// ---- hw/dacc_channel.sv ----
// One DMA channel: abort, auto-disable, sync modes and chaining
//
// Contract
// R01: Error at last element, dest sync or buffering off, self-disables.
// R02: Software disables channel on write error by clearing enable bit.
// R03: Write error before block end causes clean abort then disable.
// R04: Both sync source fields zero means software synchronized.
// R05: Dest sync, nonzero sources and prefetch on means prefetched dest sync.
// R06: Linked non-head channel with burst on issues bursts, even after abort.
// R07: Linked prefetched dest-sync channel starts reading at once.
// R08: Early hardware request waits for first read data, no empty write.
// R09: Abort on mid-transfer disable, non-end write error, read error; code skips the abort on disable or read error when drainCandidate is set.
// R10: Software recovers aborted channel by dummy soft-sync enable.
// R11: Software keeps chained channels draining cleanly.
// R12: Software turns prefetch off on chained channels.
// R13: Aborted linked channel resumes descriptor load when pause clears.
// R14: Software leaves smart standby until status bits 15 or 7 clear.
// R15: Block completion enables linked channel if that one is idle.
`timescale 1ns/10ps
module dacc_channel
	import dacc_pkg::*;
#(
	parameter int CW = 16
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic swEnable,
	input wire logic swDisableReq,
	input wire logic linkEnable,
	input wire logic chainHead,
	input wire logic pauseBit,
	input wire logic [4:0] syncSourceLow,
	input wire logic [1:0] syncSourceHigh,
	input wire logic [1:0] syncSideSelect,
	input wire logic prefetchOn,
	input wire logic writeBufferingOff,
	input wire logic destinationBurstOn,
	input wire logic drainCandidate,
	input wire logic [CW-1:0] elementCount,
	input wire logic [CW-1:0] frameCount,
	input wire logic hardwareRequestPin,
	input wire logic rdValid,
	input wire logic rdError,
	input wire logic wrAccept,
	input wire logic wrError,
	input wire logic linkTargetIdle,
	output logic channelEnabled,
	output logic descLoading,
	output logic rdRequest,
	output logic wrRequest,
	output logic wrBurst,
	output logic [3:0] wrByteEnable,
	output logic abortedFlag,
	output logic errorAutoDisable,
	output logic linkStart,
	output logic [CW-1:0] elemCounter,
	output logic [CW-1:0] frameCounter
);
	initial begin
		if (CW < 2 || CW > 32) $error("CW out of range");
	end
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		dacc_state_t state;
		logic desc;
		logic enabled;
		logic aborted;
		logic autoDis;
		logic haveData;
		logic pendReq;
		logic rdReq;
		logic wrReq;
		logic burst;
		logic [3:0] be;
		logic link;
		logic [CW-1:0] elem;
		logic [CW-1:0] frame;
	} dacc_chan_t;
	dacc_chan_t st_ff, nxt_st;
	logic hwReq;
	logic softSync;
	logic dstPrefetch;
	logic lastElem;
	logic dstSync;
	dacc_sync2 #(.W(1)) u_hwr (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.din(hardwareRequestPin),
		.dout(hwReq)
	);
	// ****************************************
	// Mode decode
	// ****************************************
	assign softSync = (syncSourceLow == 5'h00) // R04
		&& (syncSourceHigh == 2'h0);
	assign dstSync = !softSync && (syncSideSelect == SYNC_SIDE_DST);
	assign dstPrefetch = dstSync && (prefetchOn == PREFETCH_ON); // R05
	assign lastElem = (st_ff.elem + 1'b1 >= elementCount);
	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		nxt_st = st_ff;
		nxt_st.link = 1'b0;
		nxt_st.autoDis = 1'b0;
		nxt_st.wrReq = 1'b0;
		nxt_st.be = 4'h0;
		case (st_ff.state)
		DACC_IDLE: begin
			if (swEnable || (linkEnable && !chainHead)) begin
				nxt_st.enabled = 1'b1;
				nxt_st.elem = RST_COUNT[CW-1:0];
				nxt_st.frame = RST_COUNT[CW-1:0];
				nxt_st.haveData = 1'b0;
				nxt_st.pendReq = 1'b0;
				// Burst chosen fresh, never inherited from an abort
				nxt_st.burst = destinationBurstOn; // R06
				nxt_st.state = pauseBit ? DACC_DESC : DACC_RUN;
			end else if (swEnable || linkEnable) begin
				nxt_st.enabled = 1'b1;
				nxt_st.burst = destinationBurstOn;
				nxt_st.state = DACC_RUN;
			end
		end
		DACC_DESC: begin
			// Pause release resumes load regardless of prior abort
			if (!pauseBit) begin
				nxt_st.state = DACC_RUN; // R13
			end
		end
		DACC_RUN: begin
			nxt_st.rdReq = softSync || dstPrefetch || hwReq; // R07
			if (rdValid) begin
				nxt_st.haveData = 1'b1;
			end
			if (hwReq && !softSync) begin
				nxt_st.pendReq = 1'b1;
			end
			// Writes wait for real data so no empty-lane write escapes
			if ((st_ff.haveData || rdValid) &&
				(softSync || st_ff.pendReq || hwReq)) begin // R08
				nxt_st.wrReq = 1'b1;
				nxt_st.be = 4'hF;
			end
			if (st_ff.wrReq && wrAccept && !wrError) begin
				nxt_st.pendReq = 1'b0;
				if (lastElem) begin
					nxt_st.elem = RST_COUNT[CW-1:0];
					nxt_st.frame = st_ff.frame + 1'b1;
					if (st_ff.frame + 1'b1 >= frameCount) begin
						nxt_st.state = DACC_DONE;
					end
				end else begin
					nxt_st.elem = st_ff.elem + 1'b1;
				end
			end
			if (wrError && lastElem &&
				(dstSync || writeBufferingOff)) begin // R01
				nxt_st.autoDis = 1'b1;
				nxt_st.enabled = 1'b0;
				// Stale port requests must not outlive a self-disable
				nxt_st.rdReq = 1'b0;
				nxt_st.wrReq = 1'b0;
				nxt_st.be = 4'h0;
				nxt_st.haveData = 1'b0;
				nxt_st.pendReq = 1'b0;
				nxt_st.state = DACC_IDLE;
			end else if ((wrError && !lastElem) ||
				(rdError && !drainCandidate) ||
				(swDisableReq && !drainCandidate)) begin // R09
				nxt_st.state = DACC_ABORT; // R03
			end else if (swDisableReq) begin
				nxt_st.state = DACC_DONE;
			end
		end
		DACC_ABORT: begin
			nxt_st.aborted = 1'b1;
			nxt_st.enabled = 1'b0; // R03
			nxt_st.rdReq = 1'b0;
			nxt_st.haveData = 1'b0;
			nxt_st.pendReq = 1'b0;
			nxt_st.state = DACC_IDLE;
		end
		DACC_DONE: begin
			nxt_st.enabled = 1'b0;
			nxt_st.rdReq = 1'b0;
			nxt_st.haveData = 1'b0;
			// Only hand off to an idle target
			nxt_st.link = linkTargetIdle; // R15
			nxt_st.state = DACC_IDLE;
		end
		default: begin
			nxt_st.state = DACC_IDLE;
		end
		endcase
		if (swEnable && softSync && frameCount == '0) begin
			nxt_st.aborted = 1'b0;
		end
		nxt_st.desc = (nxt_st.state == DACC_DESC);
	end
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_ff <= '{state: DACC_IDLE, default: '0};
		end else begin
			st_ff <= nxt_st;
		end
	end
	// ****************************************
	// Outputs
	// ****************************************
	assign channelEnabled = st_ff.enabled;
	assign descLoading = st_ff.desc;
	assign rdRequest = st_ff.rdReq;
	assign wrRequest = st_ff.wrReq;
	assign wrBurst = st_ff.burst;
	assign wrByteEnable = st_ff.be;
	assign abortedFlag = st_ff.aborted;
	assign errorAutoDisable = st_ff.autoDis;
	assign linkStart = st_ff.link;
	assign elemCounter = st_ff.elem;
	assign frameCounter = st_ff.frame;
endmodule

// ---- dv/dacc_channel_properties.sv ----
// Port checker for one DMA channel
`timescale 1ns/10ps
module dacc_channel_chk #(
	parameter int CW = 16
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic swEnable,
	input wire logic rdValid,
	input wire logic linkTargetIdle,
	input wire logic [4:0] syncSourceLow,
	input wire logic [1:0] syncSourceHigh,
	input wire logic [CW-1:0] frameCount,
	input wire logic channelEnabled,
	input wire logic descLoading,
	input wire logic rdRequest,
	input wire logic wrRequest,
	input wire logic [3:0] wrByteEnable,
	input wire logic abortedFlag,
	input wire logic errorAutoDisable,
	input wire logic linkStart
);
	logic rdSeen_ff;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// Read data seen since enable
	always_ff @(posedge clk_sys) begin
		rdSeen_ff <= !sys_rst && channelEnabled && (rdSeen_ff || rdValid);
	end
	sequence sSoftStart;
		$rose(channelEnabled) && !descLoading && frameCount != 0
		&& syncSourceLow == 5'h00 && syncSourceHigh == 2'h0;
	endsequence
	AST_BE_FULL: assert property (wrRequest |-> wrByteEnable == 4'hF)
		else $error("write with partial byte enables");
	AST_BE_IDLE: assert property (!wrRequest |-> wrByteEnable == 4'h0)
		else $error("byte enables without write");
	AST_WR_AFTER_RD: assert property (wrRequest |-> rdSeen_ff)
		else $error("write before read data");
	AST_ABORT_OFF: assert property ($rose(abortedFlag)
		|-> ##[0:2] !channelEnabled)
		else $error("aborted channel stays enabled");
	AST_AUTO_OFF: assert property (errorAutoDisable
		|-> ##[0:1] !channelEnabled)
		else $error("channel not disabled after error");
	AST_LINK_IDLE: assert property (linkStart
		|-> $past(linkTargetIdle))
		else $error("link start to busy channel");
	AST_SOFT_READ: assert property (sSoftStart
		|-> ##[0:4] rdRequest)
		else $error("no read after enable");
	AST_SW_START: assert property (swEnable && !channelEnabled
		&& !abortedFlag && frameCount != 0 |-> ##[1:3] channelEnabled)
		else $error("software enable not taken");
endmodule
bind dacc_channel dacc_channel_chk #(.CW(CW)) chk (.clk_sys, .sys_rst,
	.swEnable, .rdValid, .linkTargetIdle, .syncSourceLow, .syncSourceHigh,
	.frameCount, .channelEnabled, .descLoading, .rdRequest, .wrRequest,
	.wrByteEnable, .abortedFlag, .errorAutoDisable, .linkStart);

// ---- dv/dacc_bus_model.sv ----
// Interconnect target model answering read and write requests
`timescale 1ns/10ps
module dacc_bus_model (
	input wire logic clk_sys,
	input wire logic rdRequest,
	input wire logic wrRequest,
	input wire logic [3:0] lat,
	input wire logic failWr,
	input wire logic failRd,
	output logic rdValid,
	output logic rdError,
	output logic wrAccept,
	output logic wrError
);
	int rdCnt = 0;
	int wrCnt = 0;
	initial {rdValid, rdError, wrAccept, wrError} = 4'h0;
	// One request in flight per port; requests seen meanwhile are ignored
	always @(posedge clk_sys) begin
		rdValid <= rdCnt == 1 && !failRd;
		rdError <= rdCnt == 1 && failRd;
		wrAccept <= wrCnt == 1 && !failWr;
		wrError <= wrCnt == 1 && failWr;
		if (rdCnt == 0 && rdRequest) rdCnt <= lat + 1;
		else if (rdCnt > 0) rdCnt <= rdCnt - 1;
		if (wrCnt == 0 && wrRequest) wrCnt <= lat + 1;
		else if (wrCnt > 0) wrCnt <= wrCnt - 1;
	end
endmodule

// ---- dv/tb.sv ----
// Self-checking bench for one DMA channel
`timescale 1ns/10ps
module tb;
	import dacc_pkg::*;
	logic clk_sys = 0, sys_rst = 1, swEnable = 0, swDisableReq = 0;
	logic linkEnable = 0, chainHead = 1, pauseBit = 0, prefetchOn = 0;
	logic writeBufferingOff = 0, destinationBurstOn = 0, drainCandidate = 0;
	logic hardwareRequestPin = 0, linkTargetIdle = 1, failWr = 0, failRd = 0;
	logic [3:0] lat = 4'h3;
	logic [4:0] syncSourceLow = 5'h00;
	logic [1:0] syncSourceHigh = 2'h0, syncSideSelect = SYNC_SIDE_DST;
	logic [15:0] elementCount = 16'h0002, frameCount = 16'h0001;
	logic rdValid, rdError, wrAccept, wrError, channelEnabled, descLoading;
	logic rdRequest, wrRequest, wrBurst, abortedFlag, errorAutoDisable;
	logic linkStart;
	logic [3:0] wrByteEnable;
	logic [15:0] elemCounter, frameCounter;
	int failures = 0, checks = 0;
	always #12.5 clk_sys = ~clk_sys;
	dacc_channel dut (.*);
	dacc_bus_model bus (.*);
	task automatic chk(string n, logic [15:0] s, logic [15:0] e);
		checks++;
		if (s !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task test_done();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task cyc(int n);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask
	// Bounded wait; a hang ends the run
	task automatic waitHi(ref logic s);
		for (int i = 0; i < 300 && s !== 1'b1; i++) cyc(1);
		if (s !== 1'b1) begin
			failures++;
			test_done();
		end
	endtask
	task automatic waitLo(ref logic s);
		for (int i = 0; i < 300 && s !== 1'b0; i++) cyc(1);
		if (s !== 1'b0) begin
			failures++;
			test_done();
		end
	endtask
	task swStart();
		swEnable = 1;
		cyc(1);
		swEnable = 0;
	endtask
	task tRun();
		swStart();
		waitHi(wrRequest);
		chk("byteEnable", wrByteEnable, 16'h000F);
		waitHi(linkStart);
		chk("linkStart", linkStart, 16'h0001);
		chk("frames", frameCounter, 16'h0001);
		chk("elems", elemCounter, 16'h0000);
		$display("run test done");
	endtask
	task tAbort();
		elementCount = 16'h0008;
		failWr = 1;
		lat = 4'h0;
		swStart();
		waitHi(abortedFlag);
		cyc(2);
		chk("abortEnable", channelEnabled, 16'h0000);
		failWr = 0;
		frameCount = 16'h0000;
		swStart();
		cyc(4);
		chk("recovered", abortedFlag, 16'h0000);
		waitLo(channelEnabled);
		frameCount = 16'h0001;
		$display("abort test done");
	endtask
	task tAuto();
		elementCount = 16'h0001;
		syncSourceLow = 5'h03;
		failWr = 1;
		for (int k = 0; k < 2; k++) begin
			// Second pass: source sync with write buffering off
			syncSideSelect = k ? SYNC_SIDE_SRC : SYNC_SIDE_DST;
			writeBufferingOff = k[0];
			swStart();
			hardwareRequestPin = 1;
			waitHi(errorAutoDisable);
			cyc(1);
			chk("autoOff", channelEnabled, 16'h0000);
			chk("noAbort", abortedFlag, 16'h0000);
			swDisableReq = 1;
			cyc(1);
			swDisableReq = 0;
			hardwareRequestPin = 0;
			chk("staysOff", channelEnabled, 16'h0000);
		end
		failWr = 0;
		syncSourceLow = 5'h00;
		syncSideSelect = SYNC_SIDE_DST;
		writeBufferingOff = 0;
		$display("auto disable test done");
	endtask
	task tPrefetch();
		syncSourceLow = 5'h03;
		prefetchOn = PREFETCH_ON;
		chainHead = 0;
		// Slow read so the request beats the first read data
		lat = 4'h8;
		linkEnable = 1;
		cyc(1);
		linkEnable = 0;
		hardwareRequestPin = 1;
		cyc(1);
		chk("prefetchRead", rdRequest, 16'h0001);
		cyc(6);
		chk("noEarlyWrite", wrRequest, 16'h0000);
		chk("noEarlyCount", elemCounter, 16'h0000);
		waitHi(wrRequest);
		chk("fullLanes", wrByteEnable, 16'h000F);
		hardwareRequestPin = 0;
		waitLo(channelEnabled);
		chk("prefetchFrames", frameCounter, 16'h0001);
		lat = 4'h0;
		syncSourceLow = 5'h00;
		prefetchOn = 0;
		$display("prefetch test done");
	endtask
	task tDisable();
		elementCount = 16'h0008;
		drainCandidate = 0;
		swStart();
		waitHi(wrRequest);
		swDisableReq = 1;
		cyc(1);
		swDisableReq = 0;
		waitHi(abortedFlag);
		chk("disableAbort", channelEnabled, 16'h0000);
		frameCount = 16'h0000;
		swStart();
		waitLo(channelEnabled);
		chk("recover2", abortedFlag, 16'h0000);
		frameCount = 16'h0001;
		failRd = 1;
		swStart();
		waitHi(abortedFlag);
		chk("readAbort", channelEnabled, 16'h0000);
		failRd = 0;
		$display("disable test done");
	endtask
	task tLink();
		chainHead = 0;
		destinationBurstOn = 1;
		prefetchOn = 0;
		drainCandidate = 1;
		pauseBit = 1;
		linkEnable = 1;
		cyc(1);
		linkEnable = 0;
		waitHi(descLoading);
		chk("descLoad", descLoading, 16'h0001);
		chk("wasAborted", abortedFlag, 16'h0001);
		pauseBit = 0;
		waitLo(descLoading);
		waitHi(wrRequest);
		chk("burst", wrBurst, 16'h0001);
		swDisableReq = 1;
		cyc(1);
		swDisableReq = 0;
		waitHi(linkStart);
		chk("drainLink", linkStart, 16'h0001);
		chk("drainOff", channelEnabled, 16'h0000);
		$display("link test done");
	endtask
	initial begin
		cyc(12);
		sys_rst = 0;
		chk("rstEnable", channelEnabled, 16'h0000);
		tRun();
		tAbort();
		tAuto();
		tPrefetch();
		tDisable();
		tLink();
		test_done();
	end
endmodule
